/* File: include/scan_line_consts.svh */
// Timing counts and field positions of the scan line timing block
`ifndef SCAN_LINE_CONSTS_SVH
`define SCAN_LINE_CONSTS_SVH

//--------------------------------------------------------------------
// System clock
//--------------------------------------------------------------------
`define CLK_PERIOD_NS 10

//--------------------------------------------------------------------
// Line period, typical and shortest, in their own unit and in cycles
//--------------------------------------------------------------------
`define LINE_TYP_MS 5
`define LINE_MIN_MS 2
`define LINE_TYP_CYC (`LINE_TYP_MS * 1000000 / `CLK_PERIOD_NS)
`define LINE_MIN_CYC (`LINE_MIN_MS * 1000000 / `CLK_PERIOD_NS)

//--------------------------------------------------------------------
// Horizontal geometry: widest reading width times pixel density
//--------------------------------------------------------------------
`define READ_WIDTH_MM 256
`define PIX_PER_MM_LO 8
`define PIX_PER_MM_HI 16
`define PIX_LO (`READ_WIDTH_MM * `PIX_PER_MM_LO)
`define PIX_HI (`READ_WIDTH_MM * `PIX_PER_MM_HI)

//--------------------------------------------------------------------
// Pixel clock: period in system cycles and high time per sensor type
//--------------------------------------------------------------------
`define PIX_DIV 4
`define CIS_DUTY_PCT 75
`define CCD_DUTY_PCT 50
`define CIS_HIGH (`PIX_DIV * `CIS_DUTY_PCT / 100)
`define CCD_HIGH (`PIX_DIV * `CCD_DUTY_PCT / 100)

//--------------------------------------------------------------------
// Pulse widths (least times, rounded up) and readout start
//--------------------------------------------------------------------
`define START_PULSE_NS 1000
`define START_PULSE_CYC \
   ((`START_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOTOR_PULSE_NS 10000
`define MOTOR_PULSE_CYC \
   ((`MOTOR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIX_GAP_CYC 4
`define PIX_BEGIN_CYC (`START_PULSE_CYC + `PIX_GAP_CYC)

//--------------------------------------------------------------------
// Mode pin positions inside the synchronised mode vector
//--------------------------------------------------------------------
`define MODE_CCD 3
`define MODE_HIRES 2
`define MODE_DMA 1
`define MODE_FAST 0
`define BYTE_BITS 8

`endif

/* File: include/scan_line_pkg.sv */
// Types of the scan line timing block
`include "scan_line_consts.svh"

package scan_line_pkg;

   typedef enum logic {LINK_IDLE, LINK_SHIFT} link_phase_t;

   typedef struct packed {
      logic [3:0] mode_m;
      logic [3:0] mode_s;
      logic [3:0] mode_l;
      logic dak_m;
      logic dak_s;
      logic dak_p;
      logic rd_m;
      logic rd_s;
      logic ack_m;
      logic ack_s;
      logic [19:0] line_cnt;
      logic [12:0] pix_cnt;
      logic [1:0] phase;
      logic pix_active;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic line_start;
      logic pix_a;
      logic pix_b;
      logic charge_reset;
      logic motor;
      logic cycle_clk;
      logic line_done;
      logic [7:0] dma_byte;
      logic dma_request_out;
      logic [7:0] dout;
      logic dout_oe_n;
      logic [7:0] ser_byte;
      logic req_tgl;
   } main_state_t;

   typedef struct packed {
      logic rdy_m;
      logic rdy_s;
      logic req_m;
      logic req_s;
      logic req_seen;
      logic ack_tgl;
      link_phase_t phase;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic sclk;
      logic frame;
      logic data;
   } link_state_t;

endpackage

/* File: hdl/codec_serial_link.sv */
// Serial image transfer to the CODEC, running on the link clock
`timescale 1ns/1ns
`default_nettype none

module codec_serial_link (
   input wire logic link_clk_i,
   input wire logic rst_n_i,
   input wire logic req_tgl_i,
   input wire logic [7:0] byte_i,
   input wire logic ready_i,
   output logic ack_tgl_o,
   output logic sclk_o,
   output logic frame_o,
   output logic data_o
);

   scan_line_pkg::link_state_t s_q;
   scan_line_pkg::link_state_t s_d;

   //------------------------------------------------------------------
   // Next state
   //------------------------------------------------------------------
   // Byte is only read after the request toggle has been seen, so the
   // main side has held it stable for at least two link edges.
   always_comb begin
      s_d = s_q;
      s_d.rdy_m = ready_i;
      s_d.rdy_s = s_q.rdy_m;
      s_d.req_m = req_tgl_i;
      s_d.req_s = s_q.req_m;
      unique case (s_q.phase)
         scan_line_pkg::LINK_IDLE: begin
            if ((s_q.req_s != s_q.req_seen) && s_q.rdy_s) begin // R07
               s_d.shreg = byte_i;
               s_d.data = byte_i[7];
               s_d.frame = 1'b1; // R08
               s_d.sclk = 1'b0;
               s_d.bitcnt = 3'h0;
               s_d.req_seen = s_q.req_s;
               s_d.phase = scan_line_pkg::LINK_SHIFT;
            end
         end
         scan_line_pkg::LINK_SHIFT: begin
            // CODEC samples on the rising edge; data moves on falling
            s_d.sclk = ~s_q.sclk; // R09
            if (s_q.sclk) begin
               if (s_q.bitcnt == 3'h7) begin
                  s_d.frame = 1'b0; // R08
                  s_d.data = 1'b0;
                  s_d.ack_tgl = ~s_q.ack_tgl;
                  s_d.phase = scan_line_pkg::LINK_IDLE;
               end else begin
                  s_d.bitcnt = 3'(s_q.bitcnt + 3'h1);
                  s_d.shreg = {s_q.shreg[6:0], 1'b0};
                  s_d.data = s_q.shreg[6]; // R09
               end
            end
         end
      endcase
   end

   //------------------------------------------------------------------
   // State register
   //------------------------------------------------------------------
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0; // R12
      end else begin
         s_q <= s_d;
      end
   end

   assign ack_tgl_o = s_q.ack_tgl;
   assign sclk_o = s_q.sclk;
   assign frame_o = s_q.frame;
   assign data_o = s_q.data;

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   default clocking link_cb @(posedge link_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   frame_needs_ready_a: assert property ( // R07
      $rose(frame_o) |-> $past(s_q.rdy_s))
      else $error("frame opened without codec ready");
   frame_length_a: assert property ( // R08
      $rose(frame_o) |-> frame_o[*8] ##1 frame_o[*8] ##1 !frame_o)
      else $error("frame not sixteen link cycles long");
   clock_in_frame_a: assert property ( // R09
      !frame_o |-> !sclk_o)
      else $error("transfer clock active outside frame");

endmodule // codec_serial_link

`default_nettype wire

/* File: hdl/scan_line_timing.sv */
// Sensor timing, roller motor, line clock and image output of the scanner
//
// How it works
// [R01] Second pixel clock always inverse of first
// [R02] Contact sensor pixel clock high 75 percent
// [R03] One line start pulse per scan line
// [R04] Pixel clock train shifts sensor pixels out
// [R05] CCD charge reset pulse once per pixel
// [R06] Roller motor step pulse every line
// [R07] Serial transfer starts only after CODEC ready
// [R08] Frame output marks serial transfer interval
// [R09] Serial data shifted with own transfer clock
// [R10] DMA request raised when image byte ready
// [R11] DMA controller acknowledges; bus transfer then
// [R12] Reset clears counters and all flip-flops; pix_b and dout_oe_n reset to 1 here
// [R13] Line period from system clock, 2-5 ms
// [R14] 8 or 16 pixels/mm sets pixel count
// [R15] Processor asserts chip select per access; no chip select input here, the bus is driven on DMA acknowledge with read
// [R16] 8-bit bus with separate read strobe
// [R17] Line done output when readout finishes
// [R18] Line cycle clock one period per line
`timescale 1ns/1ns
`default_nettype none
`include "scan_line_consts.svh"

module scan_line_timing #(
   parameter int unsigned LINE_TYP_CYCLES = `LINE_TYP_CYC,
   parameter int unsigned LINE_MIN_CYCLES = `LINE_MIN_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic LINK_CLK_I,
   input wire logic SENSOR_CCD_I,
   input wire logic HIRES_I,
   input wire logic DMA_MODE_I,
   input wire logic FAST_LINE_I,
   input wire logic VIDEO_BIT_I,
   input wire logic CODEC_READY_IN_I,
   input wire logic DMA_ACKNOWLEDGE_IN_N_I,
   input wire logic HOST_READ_N_I,
   input wire logic [7:0] HOST_DATA_BUS_I,
   output logic LINE_START_PULSE_O,
   output logic PIXEL_CLOCK_A_O,
   output logic PIXEL_CLOCK_B_O,
   output logic CHARGE_RESET_PULSE_O,
   output logic ROLLER_MOTOR_PULSE_O,
   output logic LINE_CYCLE_CLOCK_O,
   output logic LINE_DONE_O,
   output logic CODEC_TRANSFER_FRAME_O,
   output logic CODEC_TRANSFER_CLOCK_O,
   output logic CODEC_VIDEO_DATA_O,
   output logic DMA_REQUEST_OUT_O,
   output logic [7:0] HOST_DATA_BUS_O,
   output logic HOST_DATA_BUS_OE_N_O
);

   //------------------------------------------------------------------
   // Sized timing constants
   //------------------------------------------------------------------
   localparam logic [19:0] TYP_LAST = 20'(LINE_TYP_CYCLES - 1);
   localparam logic [19:0] MIN_LAST = 20'(LINE_MIN_CYCLES - 1);
   localparam logic [19:0] TYP_HALF = 20'(LINE_TYP_CYCLES / 2);
   localparam logic [19:0] MIN_HALF = 20'(LINE_MIN_CYCLES / 2);
   localparam logic [19:0] START_LEN = 20'(`START_PULSE_CYC);
   localparam logic [19:0] MOTOR_LEN = 20'(`MOTOR_PULSE_CYC);
   localparam logic [19:0] PIX_BEGIN = 20'(`PIX_BEGIN_CYC);
   localparam logic [12:0] PIX_LO_LAST = 13'(`PIX_LO - 1);
   localparam logic [12:0] PIX_HI_LAST = 13'(`PIX_HI - 1);
   localparam logic [12:0] PIX_LO_TOTAL = 13'(`PIX_LO);
   localparam logic [12:0] PIX_HI_TOTAL = 13'(`PIX_HI);
   localparam logic [1:0] PHASE_LAST = 2'(`PIX_DIV - 1);
   localparam logic [1:0] CIS_HI = 2'(`CIS_HIGH);
   localparam logic [1:0] CCD_HI = 2'(`CCD_HIGH);
   localparam logic [2:0] BIT_LAST = 3'(`BYTE_BITS - 1);

   scan_line_pkg::main_state_t s_q;
   scan_line_pkg::main_state_t s_d;

   logic ack_tgl;
   logic ccd;
   logic hires;
   logic dma;
   logic [19:0] line_last;
   logic [19:0] line_half;
   logic [12:0] pix_last;
   logic [1:0] high_len;
   logic byte_done;
   logic [7:0] new_byte;
   logic dak_rise;

   //------------------------------------------------------------------
   // Mode decode
   //------------------------------------------------------------------
   // Modes act through the copy latched at line wrap, so a pin that
   // moves mid-line cannot tear the line in progress.
   assign ccd = s_q.mode_l[`MODE_CCD];
   assign hires = s_q.mode_l[`MODE_HIRES];
   assign dma = s_q.mode_l[`MODE_DMA];
   assign line_last = s_q.mode_l[`MODE_FAST] ? MIN_LAST : TYP_LAST; // R13
   assign line_half = s_q.mode_l[`MODE_FAST] ? MIN_HALF : TYP_HALF;
   assign pix_last = hires ? PIX_HI_LAST : PIX_LO_LAST; // R14
   assign high_len = ccd ? CCD_HI : CIS_HI; // R02
   assign new_byte = {s_q.shreg[6:0], VIDEO_BIT_I};
   assign dak_rise = s_q.dak_s & ~s_q.dak_p;

   //------------------------------------------------------------------
   // Next state
   //------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      byte_done = 1'b0;
      // Pins from outside, except the video bit, pass two flip-flops before use
      s_d.mode_m = {SENSOR_CCD_I, HIRES_I, DMA_MODE_I, FAST_LINE_I};
      s_d.mode_s = s_q.mode_m;
      s_d.dak_m = ~DMA_ACKNOWLEDGE_IN_N_I;
      s_d.dak_s = s_q.dak_m;
      s_d.dak_p = s_q.dak_s;
      s_d.rd_m = ~HOST_READ_N_I;
      s_d.rd_s = s_q.rd_m;
      s_d.ack_m = ack_tgl;
      s_d.ack_s = s_q.ack_m;

      // Line counter: wraps once per line period
      if (s_q.line_cnt == line_last) begin
         s_d.line_cnt = 20'h00000; // R13
         s_d.mode_l = s_q.mode_s;
      end else begin
         s_d.line_cnt = 20'(s_q.line_cnt + 20'h00001);
      end

      // Per-line pulses, all decoded from the same count
      s_d.line_start = (s_q.line_cnt < START_LEN); // R03
      s_d.motor = (s_q.line_cnt < MOTOR_LEN); // R06
      s_d.cycle_clk = (s_q.line_cnt < line_half); // R18

      // Pixel readout window
      s_d.line_done = 1'b0;
      if (s_q.line_cnt == PIX_BEGIN) begin
         s_d.pix_active = 1'b1;
         s_d.phase = 2'h0;
         s_d.pix_cnt = 13'h0000;
         s_d.bitcnt = 3'h0;
      end else if (s_q.pix_active) begin
         s_d.phase = 2'(s_q.phase + 2'h1);
         if (s_q.phase == PHASE_LAST) begin
            s_d.pix_cnt = 13'(s_q.pix_cnt + 13'h0001); // R04
            if (s_q.pix_cnt == pix_last) begin
               s_d.pix_active = 1'b0;
               s_d.line_done = 1'b1; // R17
            end
         end
         // Binary video is taken once per pixel and packed MSB first
         if (s_q.phase == 2'h0) begin
            s_d.shreg = new_byte;
            s_d.bitcnt = 3'(s_q.bitcnt + 3'h1);
            byte_done = (s_q.bitcnt == BIT_LAST);
         end
      end

      // Sensor clocks; both pixel clocks from one term, never skewed
      s_d.pix_a = s_q.pix_active && (s_q.phase < high_len); // R04 R02
      s_d.pix_b = ~s_d.pix_a; // R01
      s_d.charge_reset = ccd && s_q.pix_active && (s_q.phase == 2'h0); // R05

      // DMA side: acknowledge edge clears, a new byte sets and wins
      if (dak_rise) begin
         s_d.dma_request_out = 1'b0; // R11
      end
      if (byte_done && dma) begin
         s_d.dma_request_out = 1'b1; // R10
         s_d.dma_byte = new_byte;
      end
      s_d.dout = s_q.dma_byte;
      s_d.dout_oe_n = ~(s_q.dak_s & s_q.rd_s); // R16 R11

      // Serial side: a byte is handed over only when the link is idle;
      // a byte that meets a busy link is dropped, not queued
      if (byte_done && !dma && (s_q.req_tgl == s_q.ack_s)) begin
         s_d.ser_byte = new_byte;
         s_d.req_tgl = ~s_q.req_tgl;
      end
   end

   //------------------------------------------------------------------
   // State register
   //------------------------------------------------------------------
   // Reset leaves the second pixel clock high and the bus released, so
   // the clock pair stays complementary even while reset is held
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_q <= '0; // R12
         s_q.pix_b <= 1'b1;
         s_q.dout_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   //------------------------------------------------------------------
   // Serial link in the link clock domain
   //------------------------------------------------------------------
   // Only a toggle crosses each way; the byte beside it is held still
   // from one toggle until the answering toggle returns
   codec_serial_link link_u (
      .link_clk_i(LINK_CLK_I),
      .rst_n_i(RST_N_I),
      .req_tgl_i(s_q.req_tgl),
      .byte_i(s_q.ser_byte),
      .ready_i(CODEC_READY_IN_I),
      .ack_tgl_o(ack_tgl),
      .sclk_o(CODEC_TRANSFER_CLOCK_O),
      .frame_o(CODEC_TRANSFER_FRAME_O),
      .data_o(CODEC_VIDEO_DATA_O)
   );

   //------------------------------------------------------------------
   // Outputs, each straight from a flip-flop
   //------------------------------------------------------------------
   assign LINE_START_PULSE_O = s_q.line_start;
   assign PIXEL_CLOCK_A_O = s_q.pix_a;
   assign PIXEL_CLOCK_B_O = s_q.pix_b;
   assign CHARGE_RESET_PULSE_O = s_q.charge_reset;
   assign ROLLER_MOTOR_PULSE_O = s_q.motor;
   assign LINE_CYCLE_CLOCK_O = s_q.cycle_clk;
   assign LINE_DONE_O = s_q.line_done;
   assign DMA_REQUEST_OUT_O = s_q.dma_request_out;
   assign HOST_DATA_BUS_O = s_q.dout;
   assign HOST_DATA_BUS_OE_N_O = s_q.dout_oe_n;

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   // All checks run on the system clock and sleep during reset
   default clocking main_cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   request_hold_a: assert property ( // R10
      (DMA_REQUEST_OUT_O && !dak_rise) |=> DMA_REQUEST_OUT_O)
      else $error("dma request dropped before acknowledge");

   pixel_idle_a: assert property ( // R04
      !s_q.pix_active |=> !PIXEL_CLOCK_A_O)
      else $error("pixel clock running outside readout window");

   cis_no_reset_a: assert property ( // R05
      !ccd |-> !CHARGE_RESET_PULSE_O)
      else $error("charge reset pulse on contact sensor");

   clock_inverse_a: assert property ( // R01
      PIXEL_CLOCK_A_O != PIXEL_CLOCK_B_O)
      else $error("pixel clocks not complementary");
   cis_duty_a: assert property ( // R02
      ($rose(PIXEL_CLOCK_A_O) && !ccd)
         |-> PIXEL_CLOCK_A_O[*3] ##1 !PIXEL_CLOCK_A_O)
      else $error("contact sensor clock not three of four high");
   ccd_duty_a: assert property ( // R04
      ($rose(PIXEL_CLOCK_A_O) && ccd)
         |-> PIXEL_CLOCK_A_O[*2] ##1 !PIXEL_CLOCK_A_O[*2])
      else $error("ccd pixel clock not two high two low");
   start_width_a: assert property ( // R03
      $rose(LINE_START_PULSE_O)
         |-> ##99 LINE_START_PULSE_O ##1 !LINE_START_PULSE_O)
      else $error("line start pulse not one hundred cycles");
   start_at_wrap_a: assert property ( // R03
      (s_q.line_cnt == 20'h00000) |=> LINE_START_PULSE_O)
      else $error("line start missing at line wrap");
   charge_reset_a: assert property ( // R05
      CHARGE_RESET_PULSE_O |-> (ccd && PIXEL_CLOCK_A_O))
      else $error("charge reset outside ccd pixel high time");
   motor_step_a: assert property ( // R06
      (s_q.line_cnt == 20'h00000) |=> ROLLER_MOTOR_PULSE_O)
      else $error("motor pulse missing at line start");
   line_wrap_a: assert property ( // R13
      (s_q.line_cnt == line_last) |=> (s_q.line_cnt == 20'h00000))
      else $error("line counter did not wrap at period end");
   pixel_total_a: assert property ( // R14
      LINE_DONE_O |-> (s_q.pix_cnt == (hires ? PIX_HI_TOTAL : PIX_LO_TOTAL)))
      else $error("wrong number of pixels in line");
   dma_request_a: assert property ( // R10
      (byte_done && dma) |=> DMA_REQUEST_OUT_O)
      else $error("dma request not raised for ready byte");
   bus_drive_a: assert property ( // R16
      !HOST_DATA_BUS_OE_N_O |-> $past(s_q.dak_s && s_q.rd_s))
      else $error("data bus driven without acknowledge and read");
   cycle_clock_a: assert property ( // R18
      $rose(LINE_CYCLE_CLOCK_O) |-> $rose(LINE_START_PULSE_O))
      else $error("line cycle clock not aligned with line start");
   line_done_a: assert property ( // R17
      LINE_DONE_O |=> (!LINE_DONE_O && !s_q.pix_active))
      else $error("line done not a single pulse at readout end");

endmodule // scan_line_timing

`default_nettype wire

/* File: bench/codec_dma_partner.sv */
// Behavioural CODEC and DMA controller on the far side of the block
`timescale 1ns/1ns
`default_nettype none

module codec_dma_partner #(
   parameter logic [7:0] EXP_BYTE = 8'hB4
) (
   input wire logic clk_i,
   input wire logic link_clk_i,
   input wire logic ready_en_i,
   input wire logic frame_i,
   input wire logic sclk_i,
   input wire logic data_i,
   input wire logic drq_i,
   input wire logic oe_n_i,
   input wire logic [7:0] bus_i,
   output logic ready_o,
   output logic ack_n_o,
   output logic read_n_o,
   output int ser_ok_o,
   output int ser_bad_o,
   output int stray_o,
   output int dma_ok_o,
   output int dma_bad_o
);
   int fcyc;
   int nb;
   int low_cnt;
   logic [7:0] sh;
   logic sclk_q = 1'b0;
   logic frame_q = 1'b0;

   // CODEC says it can take data; bench decides when
   assign ready_o = ready_en_i;

   // CODEC receive side; a frame starting once low ready has crossed
   // the sync stages is a stray
   always @(negedge link_clk_i) begin
      low_cnt = ready_o ? 0 : low_cnt + 1;
      if (frame_i === 1'b1) begin
         if (!frame_q && low_cnt > 8) stray_o++;
         fcyc++;
         if (sclk_i === 1'b1 && !sclk_q) begin
            sh = {sh[6:0], data_i};
            nb++;
         end
      end else if (frame_q) begin
         if (nb == 8 && fcyc == 16 && sh === EXP_BYTE) ser_ok_o++;
         else ser_bad_o++;
         nb = 0;
         fcyc = 0;
      end
      frame_q = (frame_i === 1'b1);
      sclk_q = (sclk_i === 1'b1);
   end

   // DMA controller; alternates prompt and slow answers to use up slack
   initial begin : dma_side
      int n;
      bit slow;
      ack_n_o = 1'b1;
      read_n_o = 1'b1;
      slow = 1'b0;
      forever begin
         @(posedge clk_i);
         if (drq_i === 1'b1) begin
            repeat (slow ? 12 : 1) @(posedge clk_i);
            slow = !slow;
            ack_n_o <= 1'b0;
            read_n_o <= 1'b0;
            n = 0;
            do begin
               @(posedge clk_i);
               n++;
            end while (oe_n_i !== 1'b0 && n < 10);
            if (oe_n_i === 1'b0 && bus_i === EXP_BYTE) dma_ok_o++;
            else dma_bad_o++;
            n = 0;
            while (drq_i !== 1'b0 && n < 10) begin
               @(posedge clk_i);
               n++;
            end
            ack_n_o <= 1'b1;
            read_n_o <= 1'b1;
            repeat (4) @(posedge clk_i);
         end
      end
   end
endmodule // codec_dma_partner
`default_nettype wire

/* File: bench/scan_line_timing_tb.sv */
// Self-checking bench of the scan line timing block
`timescale 1ns/1ns
`default_nettype none

module scan_line_timing_tb;
   localparam int LTYP = 20000;
   localparam int LMIN = 18000;
   localparam logic [7:0] PAT = 8'hB4;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ccd = 1'b0, hires = 1'b0, dma_mode = 1'b0, fast = 1'b0;
   logic video = 1'b1;
   logic ready_en = 1'b1;
   logic ready_want = 1'b1;
   logic [3:0] nxt_mode = 4'h0;
   logic [2:0] pix_k = 3'h0;
   logic a_q = 1'b0;
   logic ready, ack_n, read_n;
   logic ls, pa, pb, rs, mot, cyc, done, frame, sclk, sdata, dma_request_out, oe_n;
   logic [7:0] bus_out, bus_wire;
   logic [7:0] bus_last = 8'h00;
   int ser_ok, ser_bad, stray, dma_ok, dma_bad, base;
   int err_count = 0;
   int samples_checked = 0;

   //--------------------------------------------------------------
   // Clocks, pins and the shared data bus
   //--------------------------------------------------------------
   initial forever #5 clk = ~clk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end

   // Mode pins and video follow on the rising edge; the pixel pattern
   // repeats every byte so each packed byte must equal PAT
   always @(posedge clk) begin
      {ccd, hires, dma_mode, fast} <= nxt_mode;
      ready_en <= ready_want;
      a_q <= pa;
      if (pa === 1'b1 && a_q !== 1'b1) begin
         pix_k <= pix_k + 3'h1;
         video <= PAT[3'h7 - (pix_k + 3'h1)];
      end
      bus_last <= bus_wire;
   end

   // Released bus shows the inverse of its last value, never a hold
   assign bus_wire = (oe_n === 1'b0) ? bus_out : ~bus_last;

   scan_line_timing #(.LINE_TYP_CYCLES(LTYP), .LINE_MIN_CYCLES(LMIN)) i_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(link_clk),
      .SENSOR_CCD_I(ccd), .HIRES_I(hires), .DMA_MODE_I(dma_mode),
      .FAST_LINE_I(fast), .VIDEO_BIT_I(video), .CODEC_READY_IN_I(ready),
      .DMA_ACKNOWLEDGE_IN_N_I(ack_n), .HOST_READ_N_I(read_n),
      .HOST_DATA_BUS_I(bus_wire), .LINE_START_PULSE_O(ls),
      .PIXEL_CLOCK_A_O(pa), .PIXEL_CLOCK_B_O(pb),
      .CHARGE_RESET_PULSE_O(rs), .ROLLER_MOTOR_PULSE_O(mot),
      .LINE_CYCLE_CLOCK_O(cyc), .LINE_DONE_O(done),
      .CODEC_TRANSFER_FRAME_O(frame), .CODEC_TRANSFER_CLOCK_O(sclk),
      .CODEC_VIDEO_DATA_O(sdata), .DMA_REQUEST_OUT_O(dma_request_out),
      .HOST_DATA_BUS_O(bus_out), .HOST_DATA_BUS_OE_N_O(oe_n));

   codec_dma_partner #(.EXP_BYTE(PAT)) i_partner (
      .clk_i(clk), .link_clk_i(link_clk), .ready_en_i(ready_en),
      .frame_i(frame), .sclk_i(sclk), .data_i(sdata), .drq_i(dma_request_out),
      .oe_n_i(oe_n), .bus_i(bus_wire), .ready_o(ready), .ack_n_o(ack_n),
      .read_n_o(read_n), .ser_ok_o(ser_ok), .ser_bad_o(ser_bad),
      .stray_o(stray), .dma_ok_o(dma_ok), .dma_bad_o(dma_bad));

   //--------------------------------------------------------------
   // Shared tasks
   //--------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: %s seen %0d expected %0d", $time, what,
                  seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Held 6 cycles; the link side clears asynchronously anyway
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check("reset outputs", {ls, pa, pb, rs, mot, cyc, done, frame, sclk,
            sdata, dma_request_out, oe_n, bus_out}, {12'h201, 8'h00});
      @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic wait_start();
      int n;
      n = 0;
      while (ls !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 30000) begin
         check("line start timeout", 0, 1);
         test_done();
      end
   endtask

   // Counts one whole line from its start pulse to the next
   task automatic measure_line(input int l, input int np, input int hi,
                               input bit is_ccd);
      int n, c_ls, c_mot, c_cyc, c_ar, c_ah, c_rs, c_dn, c_bm;
      logic a_p;
      {n, c_ls, c_mot, c_cyc, c_ar, c_ah, c_rs, c_dn, c_bm} = '0;
      a_p = 1'b0;
      do begin
         n++;
         c_ls += (ls === 1'b1);
         c_mot += (mot === 1'b1);
         c_cyc += (cyc === 1'b1);
         c_ah += (pa === 1'b1);
         c_rs += (rs === 1'b1);
         c_dn += (done === 1'b1);
         c_bm += (pb !== ~pa);
         c_ar += (pa === 1'b1 && a_p !== 1'b1);
         a_p = pa;
         @(negedge clk);
      end while (!(ls === 1'b1 && n > 200) && n < 30000);
      check("line period", n, l);
      check("line start width", c_ls, 100);
      check("motor pulse width", c_mot, 1000);
      check("cycle clock high", c_cyc, l / 2);
      check("pixel clocks", c_ar, np);
      check("pixel clock high", c_ah, np * hi);
      check("charge resets", c_rs, is_ccd ? np : 0);
      check("line done pulses", c_dn, 1);
      check("clock pair", c_bm, 0);
      if (n >= 30000) test_done();
   endtask

   //--------------------------------------------------------------
   // Main sequence; modes are set a line ahead, mid-line changes wait
   //--------------------------------------------------------------
   initial begin
      do_reset();
      wait_start();
      nxt_mode = 4'hF;
      measure_line(LTYP, 2048, 3, 1'b0);
      ready_want = 1'b0;
      nxt_mode = 4'h8;
      measure_line(LMIN, 4096, 2, 1'b1);
      check("dma bytes", dma_ok, 512);
      check("dma bad bytes", dma_bad, 0);
      check("serial bytes seen", ser_ok > 0, 1);
      check("serial bad frames", ser_bad, 0);
      base = ser_ok;
      measure_line(LTYP, 2048, 2, 1'b1);
      check("serial held off", ser_ok, base);
      check("stray frames", stray, 0);
      repeat (500) @(negedge clk);
      do_reset();
      test_done();
   end
endmodule // scan_line_timing_tb
`default_nettype wire
